// [logic/bcal_pkg.sv]
package bcal_pkg;

  localparam logic [7:0] BCAL_OPT_ADDR = 8'h58;
  localparam logic [7:0] BCAL_STAT_ADDR = 8'h5C;

  localparam logic [15:0] BCAL_OPT_RESET = 16'h006A;
  localparam logic [15:0] BCAL_OPT_WMASK = 16'h01EA;
  localparam logic [7:0] BCAL_MISC_RESET = 8'h00;
  localparam logic [7:0] BCAL_MISC_WMASK = 8'h01;

  localparam int BCAL_PRI_READ_ALIAS_BIT = 1;
  localparam int BCAL_SEC_READ_ALIAS_BIT = 3;
  localparam int BCAL_PRI_LINE_ALIAS_BIT = 5;
  localparam int BCAL_SEC_LINE_ALIAS_BIT = 6;
  localparam int BCAL_PRI_WI_OFF_BIT = 7;
  localparam int BCAL_SEC_WI_OFF_BIT = 8;
  localparam int BCAL_LEGACY_EN_BIT = 0;

  localparam int BCAL_SIDE_PRI = 0;
  localparam int BCAL_SIDE_SEC = 1;

  localparam logic [3:0] BCAL_PLAIN_MEMORY_READ_CMD = 4'h6;
  localparam logic [3:0] BCAL_PLAIN_MEMORY_WRITE_CMD = 4'h7;
  localparam logic [3:0] BCAL_READ_MULTIPLE_CMD = 4'hC;
  localparam logic [3:0] BCAL_READ_LINE_CMD = 4'hE;
  localparam logic [3:0] BCAL_WRITE_AND_INVALIDATE_CMD = 4'hF;

  localparam logic [31:0] BCAL_GAME_LO = 32'h0000_0200;
  localparam logic [31:0] BCAL_GAME_HI = 32'h0000_0207;
  localparam logic [31:0] BCAL_SYNTH_LO = 32'h0000_0388;
  localparam logic [31:0] BCAL_SYNTH_HI = 32'h0000_038B;
  localparam logic [31:0] BCAL_AUDIO_LO = 32'h0000_0220;
  localparam logic [31:0] BCAL_AUDIO_HI = 32'h0000_0233;
  localparam logic [31:0] BCAL_MIDI_LO = 32'h0000_0330;
  localparam logic [31:0] BCAL_MIDI_HI = 32'h0000_0331;

  typedef struct packed {
    logic valid;
    logic [3:0] cmd;
    logic [31:0] addr;
  } bcal_req_s;

  typedef enum logic [1:0] {
    BCAL_IDLE = 2'b01,
    BCAL_ACK = 2'b10
  } bcal_bus_e;

endpackage

// [logic/bcal_bridge_alias.sv]
// Operation
// - Secondary write-invalidate alias off at 0 sends it as plain write.
// - Primary write-invalidate alias off at 0 sends it as plain write.
// - Secondary line alias on makes read-line and read-multiple interchange.
// - Primary line alias on makes read-line and read-multiple interchange.
// - Secondary plain-read alias lets line/multiple retry match pending read.
// - Primary plain-read alias lets line/multiple retry match pending read.
// - Reserved option and control bits read zero and ignore writes.
// - Legacy enable low: legacy I/O ranges neither claimed nor forwarded.
// - Legacy enable high forwards game-port and synthesizer ranges.
// - Legacy enable high forwards audio and MIDI I/O ranges downstream.
`timescale 1ns/1ps
module bcal_bridge_alias
  import bcal_pkg::*;
#(
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire bcal_req_s [1:0] wr_i,
  output bcal_req_s [1:0] wr_fwd_o,
  input wire bcal_req_s [1:0] rd_retry_i,
  input wire logic [1:0] rd_done_i,
  input wire logic [1:0][$clog2(DEPTH)-1:0] rd_done_idx_i,
  output logic [1:0] rd_hit_o,
  output logic [1:0] rd_new_o,
  output logic [1:0] rd_full_o,
  output logic [1:0][$clog2(DEPTH)-1:0] rd_idx_o,
  input wire bcal_req_s io_i,
  output logic io_claim_o
);

  localparam int IW = $clog2(DEPTH);

  function automatic logic is_line_or_multiple(input logic [3:0] c);
    is_line_or_multiple = (c == BCAL_READ_LINE_CMD) ||
                          (c == BCAL_READ_MULTIPLE_CMD);
  endfunction

  function automatic logic cmd_match(input logic [3:0] pend,
                                     input logic [3:0] retry,
                                     input logic line_on,
                                     input logic plain_on);
    cmd_match = (pend == retry) ||
                (line_on && is_line_or_multiple(pend) &&
                 is_line_or_multiple(retry)) ||
                (plain_on && (pend == BCAL_PLAIN_MEMORY_READ_CMD) &&
                 is_line_or_multiple(retry));
  endfunction

  function automatic logic in_range(input logic [31:0] a,
                                    input logic [31:0] lo,
                                    input logic [31:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  logic [15:0] opt_q;
  logic [7:0] misc_q;
  bcal_bus_e bus_q;
  logic [31:0] rdata_q;
  logic [1:0][DEPTH-1:0] ent_v_q;
  logic [31:0] ent_addr_q [2][DEPTH];
  logic [3:0] ent_cmd_q [2][DEPTH];
  logic [1:0] wi_off;
  logic [1:0] line_on;
  logic [1:0] plain_on;
  logic [1:0] hit_d;
  logic [1:0] free_d;
  logic [1:0][IW-1:0] hit_idx_d;
  logic [1:0][IW-1:0] free_idx_d;
  logic bus_req;
  logic legacy_hit;

  assign bus_req = wb_cyc_i && wb_stb_i && (bus_q == BCAL_IDLE);
  assign wb_ack_o = (bus_q == BCAL_ACK);
  assign wb_dat_o = rdata_q;

  assign wi_off[BCAL_SIDE_PRI] = opt_q[BCAL_PRI_WI_OFF_BIT];
  assign wi_off[BCAL_SIDE_SEC] = opt_q[BCAL_SEC_WI_OFF_BIT];
  assign line_on[BCAL_SIDE_PRI] = opt_q[BCAL_PRI_LINE_ALIAS_BIT];
  assign line_on[BCAL_SIDE_SEC] = opt_q[BCAL_SEC_LINE_ALIAS_BIT];
  assign plain_on[BCAL_SIDE_PRI] = opt_q[BCAL_PRI_READ_ALIAS_BIT];
  assign plain_on[BCAL_SIDE_SEC] = opt_q[BCAL_SEC_READ_ALIAS_BIT];

  // The answer comes one cycle after the request and lasts one cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_q <= BCAL_IDLE;
    end else begin
      case (bus_q)
        BCAL_IDLE: begin
          if (bus_req) begin
            bus_q <= BCAL_ACK;
          end
        end
        BCAL_ACK: bus_q <= BCAL_IDLE;
        default: bus_q <= BCAL_IDLE;
      endcase
    end
  end

  // Only writable bits are touched, so reserved positions stay at zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      opt_q <= BCAL_OPT_RESET;
      misc_q <= BCAL_MISC_RESET;
    end else if (bus_req && wb_we_i && (wb_adr_i == BCAL_OPT_ADDR)) begin
      if (wb_sel_i[0]) begin
        opt_q[7:0] <= wb_dat_i[7:0] & BCAL_OPT_WMASK[7:0];
      end
      if (wb_sel_i[1]) begin
        opt_q[15:8] <= wb_dat_i[15:8] & BCAL_OPT_WMASK[15:8];
      end
      if (wb_sel_i[2]) begin
        misc_q <= wb_dat_i[23:16] & BCAL_MISC_WMASK;
      end
    end
  end

  // Unmapped offsets are acknowledged and read as zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (bus_req) begin
      if (wb_adr_i == BCAL_OPT_ADDR) begin
        rdata_q <= {8'h00, misc_q, opt_q};
      end else if (wb_adr_i == BCAL_STAT_ADDR) begin
        rdata_q <= {16'h0000, 8'(ent_v_q[BCAL_SIDE_SEC]),
                    8'(ent_v_q[BCAL_SIDE_PRI])};
      end else begin
        rdata_q <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_fwd_o <= '0;
    end else begin
      for (int s = 0; s < 2; s++) begin
        wr_fwd_o[s] <= wr_i[s];
        if (wr_i[s].cmd == BCAL_WRITE_AND_INVALIDATE_CMD && !wi_off[s]) begin
          wr_fwd_o[s].cmd <= BCAL_PLAIN_MEMORY_WRITE_CMD;
        end
      end
    end
  end

  // The lowest matching entry wins when several could answer one retry.
  always_comb begin
    hit_d = '0;
    free_d = '0;
    hit_idx_d = '0;
    free_idx_d = '0;
    for (int s = 0; s < 2; s++) begin
      for (int e = DEPTH - 1; e >= 0; e--) begin
        if (ent_v_q[s][e] && ent_addr_q[s][e] == rd_retry_i[s].addr &&
            cmd_match(ent_cmd_q[s][e], rd_retry_i[s].cmd, line_on[s],
                      plain_on[s])) begin
          hit_d[s] = 1'b1;
          hit_idx_d[s] = IW'(e);
        end
        if (!ent_v_q[s][e]) begin
          free_d[s] = 1'b1;
          free_idx_d[s] = IW'(e);
        end
      end
    end
  end

  // A full queue refuses a new request; the initiator simply retries later.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ent_v_q <= '0;
      for (int s = 0; s < 2; s++) begin
        for (int e = 0; e < DEPTH; e++) begin
          ent_addr_q[s][e] <= 32'h0000_0000;
          ent_cmd_q[s][e] <= 4'h0;
        end
      end
    end else begin
      for (int s = 0; s < 2; s++) begin
        if (rd_done_i[s]) begin
          ent_v_q[s][rd_done_idx_i[s]] <= 1'b0;
        end
        if (rd_retry_i[s].valid && !hit_d[s] && free_d[s]) begin
          ent_v_q[s][free_idx_d[s]] <= 1'b1;
          ent_addr_q[s][free_idx_d[s]] <= rd_retry_i[s].addr;
          ent_cmd_q[s][free_idx_d[s]] <= rd_retry_i[s].cmd;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_hit_o <= '0;
      rd_new_o <= '0;
      rd_full_o <= '0;
      rd_idx_o <= '0;
    end else begin
      for (int s = 0; s < 2; s++) begin
        rd_hit_o[s] <= rd_retry_i[s].valid && hit_d[s];
        rd_new_o[s] <= rd_retry_i[s].valid && !hit_d[s] && free_d[s];
        rd_full_o[s] <= rd_retry_i[s].valid && !hit_d[s] && !free_d[s];
        rd_idx_o[s] <= hit_d[s] ? hit_idx_d[s] : free_idx_d[s];
      end
    end
  end

  assign legacy_hit =
    in_range(io_i.addr, BCAL_GAME_LO, BCAL_GAME_HI) ||
    in_range(io_i.addr, BCAL_SYNTH_LO, BCAL_SYNTH_HI) ||
    in_range(io_i.addr, BCAL_AUDIO_LO, BCAL_AUDIO_HI) ||
    in_range(io_i.addr, BCAL_MIDI_LO, BCAL_MIDI_HI);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      io_claim_o <= 1'b0;
    end else begin
      io_claim_o <= io_i.valid && legacy_hit &&
                    misc_q[BCAL_LEGACY_EN_BIT];
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_sec_wi;
    wr_i[1].valid && wr_i[1].cmd == BCAL_WRITE_AND_INVALIDATE_CMD &&
      !opt_q[BCAL_SEC_WI_OFF_BIT]
      |=> wr_fwd_o[1].valid && wr_fwd_o[1].cmd == BCAL_PLAIN_MEMORY_WRITE_CMD;
  endproperty
  a_sec_wi: assert property (p_sec_wi)
    else $error("Secondary write-invalidate not converted.");

  property p_sec_wi_keep;
    wr_i[1].valid && wr_i[1].cmd == BCAL_WRITE_AND_INVALIDATE_CMD &&
      opt_q[BCAL_SEC_WI_OFF_BIT]
      |=> wr_fwd_o[1].cmd == BCAL_WRITE_AND_INVALIDATE_CMD;
  endproperty
  a_sec_wi_keep: assert property (p_sec_wi_keep)
    else $error("Secondary write-invalidate changed while alias is off.");

  property p_pri_wi;
    wr_i[0].valid && wr_i[0].cmd == BCAL_WRITE_AND_INVALIDATE_CMD
      |=> wr_fwd_o[0].cmd == ($past(opt_q[BCAL_PRI_WI_OFF_BIT]) ?
          BCAL_WRITE_AND_INVALIDATE_CMD : BCAL_PLAIN_MEMORY_WRITE_CMD);
  endproperty
  a_pri_wi: assert property (p_pri_wi)
    else $error("Primary write-invalidate forwarded wrongly.");

  property p_sec_line;
    rd_retry_i[1].valid && ent_v_q[1][0] && opt_q[BCAL_SEC_LINE_ALIAS_BIT] &&
      ent_addr_q[1][0] == rd_retry_i[1].addr &&
      is_line_or_multiple(ent_cmd_q[1][0]) &&
      is_line_or_multiple(rd_retry_i[1].cmd)
      |=> rd_hit_o[1] && !rd_new_o[1];
  endproperty
  a_sec_line: assert property (p_sec_line)
    else $error("Secondary line alias missed.");

  property p_pri_line;
    rd_retry_i[0].valid && ent_v_q[0][0] && opt_q[BCAL_PRI_LINE_ALIAS_BIT] &&
      ent_addr_q[0][0] == rd_retry_i[0].addr &&
      is_line_or_multiple(ent_cmd_q[0][0]) &&
      is_line_or_multiple(rd_retry_i[0].cmd)
      |=> rd_hit_o[0] && !rd_new_o[0];
  endproperty
  a_pri_line: assert property (p_pri_line)
    else $error("Primary line alias missed.");

  property p_sec_plain;
    rd_retry_i[1].valid && ent_v_q[1][0] && opt_q[BCAL_SEC_READ_ALIAS_BIT] &&
      ent_addr_q[1][0] == rd_retry_i[1].addr &&
      ent_cmd_q[1][0] == BCAL_PLAIN_MEMORY_READ_CMD &&
      is_line_or_multiple(rd_retry_i[1].cmd)
      |=> rd_hit_o[1] && !rd_new_o[1];
  endproperty
  a_sec_plain: assert property (p_sec_plain)
    else $error("Secondary plain-read alias missed.");

  property p_pri_plain;
    rd_retry_i[0].valid && ent_v_q[0][0] && opt_q[BCAL_PRI_READ_ALIAS_BIT] &&
      ent_addr_q[0][0] == rd_retry_i[0].addr &&
      ent_cmd_q[0][0] == BCAL_PLAIN_MEMORY_READ_CMD &&
      is_line_or_multiple(rd_retry_i[0].cmd)
      |=> rd_hit_o[0] && !rd_new_o[0];
  endproperty
  a_pri_plain: assert property (p_pri_plain)
    else $error("Primary plain-read alias missed.");

  property p_reserved;
    (opt_q & ~BCAL_OPT_WMASK) == 16'h0000 &&
      (misc_q & ~BCAL_MISC_WMASK) == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("Reserved bit became set.");

  property p_legacy_off;
    !misc_q[BCAL_LEGACY_EN_BIT] |=> !io_claim_o;
  endproperty
  a_legacy_off: assert property (p_legacy_off)
    else $error("Legacy range claimed while disabled.");

  property p_game;
    io_i.valid && misc_q[BCAL_LEGACY_EN_BIT] &&
      (in_range(io_i.addr, BCAL_GAME_LO, BCAL_GAME_HI) ||
       in_range(io_i.addr, BCAL_SYNTH_LO, BCAL_SYNTH_HI)) |=> io_claim_o;
  endproperty
  a_game: assert property (p_game)
    else $error("Game or synthesizer access not forwarded.");

  property p_audio;
    io_i.valid && misc_q[BCAL_LEGACY_EN_BIT] &&
      (in_range(io_i.addr, BCAL_AUDIO_LO, BCAL_AUDIO_HI) ||
       in_range(io_i.addr, BCAL_MIDI_LO, BCAL_MIDI_HI)) |=> io_claim_o;
  endproperty
  a_audio: assert property (p_audio)
    else $error("Audio or MIDI access not forwarded.");

  property p_new_entry;
    rd_retry_i[1].valid && ent_v_q[1] == '0
      |=> rd_new_o[1] && ent_v_q[1][rd_idx_o[1]] ##1 ent_v_q[1] != '0;
  endproperty
  a_new_entry: assert property (p_new_entry)
    else $error("Unmatched retry not registered.");

  property p_ack_once;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("Register bus acknowledge out of step.");

  c_hit: cover property (rd_new_o[0] ##[1:20] rd_hit_o[0]);
  c_full: cover property (rd_full_o[1]);
  c_claim: cover property (io_claim_o);
  c_wi: cover property (wr_fwd_o[1].valid &&
                        wr_fwd_o[1].cmd == BCAL_PLAIN_MEMORY_WRITE_CMD);

endmodule // bcal_bridge_alias

// [verification/bcal_initiator.sv]
`timescale 1ns/1ps
module bcal_initiator
  import bcal_pkg::*;
#(
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  output bcal_req_s [1:0] wr_o,
  output bcal_req_s [1:0] rd_retry_o,
  output logic [1:0] rd_done_o,
  output logic [1:0][$clog2(DEPTH)-1:0] rd_done_idx_o,
  output bcal_req_s io_o
);
  initial begin
    wr_o = '0;
    rd_retry_o = '0;
    rd_done_o = '0;
    rd_done_idx_o = '0;
    io_o = '0;
  end
  task automatic put(input int k, input int s, input bcal_req_s r);
    case (k)
      0: wr_o[s] <= r;
      1: rd_retry_o[s] <= r;
      default: io_o <= r;
    endcase
  endtask
  // Released fields turn inverted, so a stale copy cannot pass unseen.
  task automatic send(input int k, input int s, input logic [3:0] c,
                      input logic [31:0] a);
    @(posedge clk_i);
    put(k, s, {1'b1, c, a});
    @(posedge clk_i);
    put(k, s, {1'b0, ~c, ~a});
  endtask
  task automatic free(input int s, input int i);
    @(posedge clk_i);
    rd_done_o[s] <= 1'b1;
    rd_done_idx_o[s] <= i[$clog2(DEPTH)-1:0];
    @(posedge clk_i);
    rd_done_o[s] <= 1'b0;
    rd_done_idx_o[s] <= ~i[$clog2(DEPTH)-1:0];
  endtask
endmodule // bcal_initiator

// [verification/bcal_bridge_alias_test.sv]
`timescale 1ns/1ps
module bcal_bridge_alias_test
  import bcal_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, q, a, a2;
  logic ack, claim, m;
  bcal_req_s [1:0] wr, fwd, rty;
  bcal_req_s io;
  logic [1:0] done, hit, nw, full;
  logic [1:0][1:0] didx, idx;
  logic [15:0] opt;
  logic [3:0] c1, c2;
  logic [3:0] rc [3] = '{4'h6, 4'hC, 4'hE};
  logic [11:0] eg [16] = '{12'h1FF, 12'h200, 12'h207, 12'h208, 12'h21F,
    12'h220, 12'h233, 12'h234, 12'h32F, 12'h330, 12'h331, 12'h332,
    12'h387, 12'h388, 12'h38B, 12'h38C};
  int bad_count = 0;
  int cmp_count = 0;
  always #4 clk_i = ~clk_i;
  bcal_initiator #(.DEPTH(4)) i_ini (.clk_i(clk_i), .wr_o(wr),
    .rd_retry_o(rty), .rd_done_o(done), .rd_done_idx_o(didx), .io_o(io));
  bcal_bridge_alias #(.DEPTH(4)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wr_i(wr), .wr_fwd_o(fwd), .rd_retry_i(rty), .rd_done_i(done),
    .rd_done_idx_i(didx), .rd_hit_o(hit), .rd_new_o(nw), .rd_full_o(full),
    .rd_idx_o(idx), .io_i(io), .io_claim_o(claim));
  task automatic give_verdict();
    if (bad_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] r);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rchk(input int s, input logic [2:0] f, input int i);
    #1;
    chk({hit[s], nw[s], full[s]}, f);
    if (!f[0]) chk(idx[s], i);
  endtask
  function automatic logic exp_hit(logic [3:0] p, logic [3:0] r,
                                   logic ln, logic pl);
    logic lm;
    lm = r == 4'hC || r == 4'hE;
    return p == r || (ln && lm && (p == 4'hC || p == 4'hE)) ||
      (pl && p == 4'h6 && lm);
  endfunction
  function automatic logic in_leg(logic [31:0] x);
    return (x >= 32'h200 && x <= 32'h207) || (x >= 32'h388 && x <= 32'h38B)
      || (x >= 32'h220 && x <= 32'h233) || (x >= 32'h330 && x <= 32'h331);
  endfunction
  initial begin
    #200000;
    bad_count++;
    give_verdict();
  end
  initial begin
    void'($urandom(71838));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, BCAL_OPT_ADDR, 32'h0, 4'hF, q);
    chk(q, 32'h0000_006A);
    wb(1'b1, BCAL_OPT_ADDR, 32'hFFFF_FFFF, 4'hB, q);
    wb(1'b0, BCAL_OPT_ADDR, 32'h0, 4'hF, q);
    chk(q, 32'h0000_01EA);
    wb(1'b1, 8'h10, 32'hFFFF_FFFF, 4'hF, q);
    wb(1'b0, 8'h10, 32'h0, 4'hF, q);
    chk(q, 32'h0);
    for (int n = 0; n < 40; n++) begin
      opt = 16'($urandom());
      wb(1'b1, BCAL_OPT_ADDR, {16'h0, opt}, 4'h3, q);
      wb(1'b0, BCAL_OPT_ADDR, 32'h0, 4'h3, q);
      chk(q, {16'h0, opt & 16'h01EA});
      for (int s = 0; s < 2; s++) begin
        c1 = ($urandom() & 1) ? 4'hF : 4'h7;
        a = $urandom();
        i_ini.send(0, s, c1, a);
        #1;
        c2 = (c1 == 4'hF && !opt[7+s]) ? 4'h7 : c1;
        chk(fwd[s], {1'b1, c2, a});
        c1 = rc[$urandom_range(2)];
        c2 = rc[$urandom_range(2)];
        a2 = ($urandom() & 3) ? a : a + 32'h4;
        i_ini.send(1, s, c1, a);
        rchk(s, 3'b010, 0);
        i_ini.send(1, s, c2, a2);
        m = a2 == a && exp_hit(c1, c2, opt[5+s], opt[1+2*s]);
        rchk(s, m ? 3'b100 : 3'b010, m ? 0 : 1);
        i_ini.free(s, 0);
        i_ini.free(s, 1);
      end
    end
    // Four new entries, one every other cycle, then one more that the full queue refuses.
    for (int i = 0; i < 5; i++) begin
      i_ini.send(1, 1, 4'h6, 32'h100 * i);
      rchk(1, i < 4 ? 3'b010 : 3'b001, i);
    end
    wb(1'b0, BCAL_STAT_ADDR, 32'h0, 4'hF, q);
    chk(q, 32'h0000_0F00);
    for (int i = 0; i < 4; i++) i_ini.free(1, i);
    for (int e = 0; e < 2; e++) begin
      wb(1'b1, BCAL_OPT_ADDR, {8'hFF, 7'h7F, 1'(e), 16'h0}, 4'hC, q);
      wb(1'b0, BCAL_OPT_ADDR, 32'h0, 4'hF, q);
      chk(q[31:16], {15'h0, 1'(e)});
      for (int i = 0; i < 24; i++) begin
        a = i < 16 ? {20'h0, eg[i]} : $urandom() & 32'h0001_03FF;
        i_ini.send(2, 0, 4'h2, a);
        #1;
        chk(claim, e && in_leg(a));
      end
    end
    give_verdict();
  end
endmodule // bcal_bridge_alias_test
